//--- sfm_consts.svh
// Constants of the supply fault monitor
`ifndef SFM_CONSTS_SVH
`define SFM_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SFM_CLK_PERIOD_NS    10
`define SFM_MS_TIME_NS       1000000
`define SFM_MS_CYCLES        (`SFM_MS_TIME_NS / `SFM_CLK_PERIOD_NS)
`define SFM_PREWARN_MAX_MS   16'd1280
`define SFM_REVERSAL_MS      16'd30000
`define SFM_TENTH_MS         8'd100
`define SFM_GAP_MAX_DEG      10'd450

// ----------------------------------------
// Ratios, repeat count and depths
// ----------------------------------------
`define SFM_PCT_FULL         32'd100
`define SFM_FIELD_SP_MIN_PCT 32'd2
`define SFM_PREWARN_REPEAT   4'h4
`define SFM_DETAIL_DEPTH     16
`define SFM_HISTORY_DEPTH    8

// ----------------------------------------
// Fault values
// ----------------------------------------
`define SFM_ELEC_OUTAGE      8'h01
`define SFM_ELEC_PERIODIC    8'h02
`define SFM_ELEC_LONG        8'h03
`define SFM_ARM_LOSS_NOWAIT  8'h01
`define SFM_ARM_WAIT_TIMEOUT 8'h02
`define SFM_ARM_FUSE         8'h03
`define SFM_ARM_LOSS_RESTART 8'h04
`define SFM_ARM_CHECKBACK    8'h05
`define SFM_FLD_LOSS_NOWAIT  8'h01
`define SFM_FLD_WAIT_VOLT    8'h02
`define SFM_FLD_WAIT_CURR    8'h03
`define SFM_FLD_RESTART      8'h04
`define SFM_FLD_LOW_NOWAIT   8'h05
`define SFM_FLD_NO_DECAY     8'h06
`define SFM_FLD_NO_BUILD     8'h07

`endif

//--- sfm_front_end_model.sv
// Front end model: supply waveforms, field supply and contactor checkback
`timescale 1ns/1ps

module sfm_front_end_model (
	input  wire logic       core_clk,
	input  wire logic [2:0] armLoss,
	input  wire logic       fieldLoss,
	input  wire logic       contactorOn,
	input  wire logic       cbFail,
	output logic            degTick,
	output logic [2:0]      armZeroCross,
	output logic [2:0]      armRmsValid,
	output logic [47:0]     armRms,
	output logic            fieldZeroCross,
	output logic            fieldRmsValid,
	output logic [15:0]     fieldRms,
	output logic            checkbackPin
);
	logic [8:0] deg   = 9'h000;
	logic [2:0] cbDly = 3'h0;

	initial
	begin
		{degTick, armZeroCross, armRmsValid, armRms} = 55'h0;
		{fieldZeroCross, fieldRmsValid, fieldRms, checkbackPin} = 19'h0;
	end

	// Lost phases skip crossings and give low RMS; idle RMS lines show the inverse
	always @(negedge core_clk)
	begin
		degTick <= !degTick;
		if (degTick)
			deg <= (deg == 9'h167) ? 9'h000 : deg + 9'h001;
		for (int p = 0; p < 3; p++)
		begin
			armZeroCross[p] <= !degTick && !armLoss[p] && deg == 9'(p * 120);
			armRmsValid[p] <= !degTick && deg == 9'(p * 120 + 60);
			armRms[p*16+:16] <= (armLoss[p] ? 16'h0010 : 16'h0100)
				^ {16{!(!degTick && deg == 9'(p * 120 + 60))}};
		end
		fieldZeroCross <= !degTick && !fieldLoss && deg == 9'h000;
		fieldRmsValid <= !degTick && deg == 9'h0b4;
		fieldRms <= (fieldLoss ? 16'h0010 : 16'h0100) ^ {16{!(!degTick && deg == 9'h0b4)}};
		cbDly <= {cbDly[1:0], contactorOn};
		checkbackPin <= cbDly[2] && !cbFail;
	end
endmodule

//--- sfm_monitor_checker.sv
// Port checker for the supply fault monitor
`timescale 1ns/1ps

module sfm_monitor_checker (
	input wire logic                core_clk,
	input wire logic                sys_rst,
	input wire logic                faultAck,
	input wire logic                faultActive,
	input wire sfm_pkg::sfm_class_e faultClass,
	input wire logic [7:0]          faultValue
);
	default clocking dcb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	rst_clears_a: assert property ($fell(sys_rst) |-> !faultActive && faultValue == 8'h00)
		else $error("fault state not cleared by reset");
	held_stable_a: assert property (faultActive && !faultAck |=>
		faultActive && $stable(faultValue) && $stable(faultClass))
		else $error("held fault changed without acknowledge");
	idle_stable_a: assert property (!faultActive |=>
		faultActive || ($stable(faultValue) && $stable(faultClass)))
		else $error("fault value changed while idle");
	ack_clears_a: assert property (faultActive && faultAck |-> ##1 !faultActive)
		else $error("acknowledge did not release the fault");
	ack_keeps_a: assert property ($fell(faultActive) && !$past(sys_rst) |->
		$stable(faultValue) && $stable(faultClass))
		else $error("fault value lost on acknowledge");
	active_valid_a: assert property (faultActive |->
		faultClass != sfm_pkg::SFM_FC_NONE && faultValue != 8'h00)
		else $error("held fault without class or value");
	elec_values_a: assert property (faultActive && faultClass == sfm_pkg::SFM_FC_ELEC |->
		faultValue inside {8'h01, 8'h02, 8'h03})
		else $error("bad electronics fault value");
	arm_values_a: assert property (faultActive && faultClass == sfm_pkg::SFM_FC_ARM |->
		faultValue inside {[8'h01:8'h05]})
		else $error("bad armature fault value");
	field_values_a: assert property (faultActive && faultClass == sfm_pkg::SFM_FC_FIELD |->
		faultValue inside {[8'h01:8'h07]})
		else $error("bad field fault value");

	cover property ($rose(faultActive) && faultClass == sfm_pkg::SFM_FC_ELEC);
	cover property ($rose(faultActive) && faultClass == sfm_pkg::SFM_FC_ARM);
	cover property ($rose(faultActive) && faultClass == sfm_pkg::SFM_FC_FIELD);
	cover property (faultActive && faultAck);
endmodule

bind sfm_supply_fault_monitor sfm_monitor_checker sfm_monitor_checker_inst (
	.core_clk(core_clk),
	.sys_rst(sys_rst),
	.faultAck(faultAck),
	.faultActive(faultActive),
	.faultClass(faultClass),
	.faultValue(faultValue)
);

//--- sfm_persist.sv
// Persistence timer counting millisecond ticks while a condition holds
`timescale 1ns/1ps

module sfm_persist #(
	parameter int WIDTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             msTick,
	input  wire logic             cond,
	input  wire logic [WIDTH-1:0] limit,
	output logic                  expired
);

	logic [WIDTH-1:0] count_q;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst || !cond)
			count_q <= '0;
		else if (msTick && count_q != '1)
			count_q <= count_q + 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			expired <= 1'b0;
		else
			expired <= cond && (count_q > limit);
	end

endmodule

//--- sfm_pkg.sv
// Types of the supply fault monitor
package sfm_pkg;

	typedef enum logic [1:0]
	{
		SFM_ST_IDLE = 2'b01,
		SFM_ST_HOLD = 2'b10
	} sfm_state_e;

	typedef enum logic [1:0]
	{
		SFM_FC_NONE  = 2'h0,
		SFM_FC_ELEC  = 2'h1,
		SFM_FC_ARM   = 2'h2,
		SFM_FC_FIELD = 2'h3
	} sfm_class_e;

endpackage

//--- sfm_supply_fault_monitor.sv
// Supply, armature phase and field circuit fault monitor with fault record
`timescale 1ns/1ps
`include "sfm_consts.svh"

module sfm_supply_fault_monitor #(
	parameter int NPH       = 3,
	parameter int MS_CYCLES = `SFM_MS_CYCLES,
	parameter int DETAILS   = `SFM_DETAIL_DEPTH,
	parameter int HISTORY   = `SFM_HISTORY_DEPTH
) (
	input  wire logic                core_clk,
	input  wire logic                sys_rst,
	input  wire logic                elecSupplyOkPin,
	input  wire logic                prewarnPin,
	input  wire logic                fuseBlownPin,
	input  wire logic                checkbackPin,
	input  wire logic                checkbackWord,
	input  wire logic                checkbackSourceSelect,
	input  wire logic                opRun,
	input  wire logic                opArmWaitState,
	input  wire logic                opFieldWaitState,
	input  wire logic                opAtMostArmWait,
	input  wire logic                lineContactorOn,
	input  wire logic                degTick,
	input  wire logic [NPH-1:0]      armZeroCross,
	input  wire logic [NPH-1:0]      armRmsValid,
	input  wire logic [NPH*16-1:0]   armRms,
	input  wire logic                fieldZeroCross,
	input  wire logic                fieldRmsValid,
	input  wire logic [15:0]         fieldRms,
	input  wire logic [15:0]         ratedSupplyVoltage,
	input  wire logic [15:0]         ratedFieldSupplyVoltage,
	input  wire logic [7:0]          phaseLossThresholdPct,
	input  wire logic [15:0]         restartTime,
	input  wire logic [15:0]         powerWaitTime,
	input  wire logic [15:0]         checkbackTimeout,
	input  wire logic [15:0]         fieldCurrentActual,
	input  wire logic [15:0]         fieldCurrentSetpoint,
	input  wire logic [15:0]         ratedFieldCurrent,
	input  wire logic [7:0]          fieldLowRatioLimit,
	input  wire logic [15:0]         fieldLowTimeLimit,
	input  wire logic [15:0]         fieldMinThreshold,
	input  wire logic [15:0]         fieldBuildupThreshold,
	input  wire logic                fieldReduceActive,
	input  wire logic                fieldBuildActive,
	input  wire logic                faultAck,
	input  wire logic [3:0]          detailIndex,
	input  wire logic [2:0]          historyIndex,
	output logic                     faultActive,
	output sfm_pkg::sfm_class_e      faultClass,
	output logic [7:0]               faultValue,
	output logic [15:0]              detailData,
	output logic [7:0]               historyData
);

	// ----------------------------------------
	// Pin synchronisers and millisecond tick
	// ----------------------------------------
	logic        elecOk;
	logic        prewarn;
	logic        fuseBlown;
	logic        checkbackPinS;
	logic        checkback;
	logic [31:0] msCnt_q;
	logic        msTick;

	sfm_sync #(
		.WIDTH(4)
	) u_sync (
		.core_clk(core_clk),
		.sys_rst (sys_rst),
		.asyncIn ({elecSupplyOkPin, prewarnPin, fuseBlownPin, checkbackPin}),
		.syncOut ({elecOk, prewarn, fuseBlown, checkbackPinS})
	);

	assign checkback = checkbackSourceSelect ? checkbackWord : checkbackPinS;
	assign msTick    = (msCnt_q == 32'(MS_CYCLES - 1));

	always_ff @(posedge core_clk)
	begin
		if (sys_rst || msTick)
			msCnt_q <= '0;
		else
			msCnt_q <= msCnt_q + 32'd1;
	end

	// ----------------------------------------
	// Per-phase RMS and zero-crossing checks
	// ----------------------------------------
	logic [NPH:0]      zcAll;
	logic [NPH:0]      rmsValidAll;
	logic [NPH*16+15:0] rmsAll;
	logic [NPH:0]      phaseBad;
	logic              armBad;
	logic              fieldVoltBad;

	assign zcAll       = {fieldZeroCross, armZeroCross};
	assign rmsValidAll = {fieldRmsValid, armRmsValid};
	assign rmsAll      = {fieldRms, armRms};

	generate
		for (genvar ph = 0; ph <= NPH; ph++)
		begin : g_phase
			logic [9:0]  gap_q;
			logic        rmsOk_q;
			logic [31:0] lhs;
			logic [31:0] rhs;

			assign lhs = {16'h0, rmsAll[ph*16 +: 16]} * `SFM_PCT_FULL;
			assign rhs = {16'h0, (ph == NPH) ? ratedFieldSupplyVoltage : ratedSupplyVoltage}
				* {24'h0, phaseLossThresholdPct};

			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
					rmsOk_q <= 1'b1;
				else if (rmsValidAll[ph])
					rmsOk_q <= lhs > rhs;
			end

			always_ff @(posedge core_clk)
			begin
				if (sys_rst || zcAll[ph])
					gap_q <= '0;
				else if (degTick && gap_q <= `SFM_GAP_MAX_DEG)
					gap_q <= gap_q + 10'd1;
			end

			assign phaseBad[ph] = !rmsOk_q || (gap_q > `SFM_GAP_MAX_DEG);
		end
	endgenerate

	assign armBad       = |phaseBad[NPH-1:0];
	assign fieldVoltBad = phaseBad[NPH];

	// ----------------------------------------
	// Field current checks
	// ----------------------------------------
	logic fieldLowArmed;
	logic fieldLowRaw;
	logic fieldLowFlag;
	logic fieldBad;

	assign fieldLowArmed = {16'h0, fieldCurrentSetpoint} * `SFM_PCT_FULL
		> {16'h0, ratedFieldCurrent} * `SFM_FIELD_SP_MIN_PCT;
	assign fieldLowRaw   = fieldLowArmed && ({16'h0, fieldCurrentActual} * `SFM_PCT_FULL
		< {16'h0, fieldCurrentSetpoint} * {24'h0, fieldLowRatioLimit});
	assign fieldBad      = fieldVoltBad || fieldLowFlag;

	// ----------------------------------------
	// Persistence timers
	// ----------------------------------------
	logic elecExp;
	logic prewarnExp;
	logic quietExp;
	logic armExp;
	logic fieldExp;
	logic waitExp;
	logic checkExp;
	logic revExp;
	logic prewarnRise;
	logic armGate;
	logic checkbackSeen_q;

	assign armGate = opAtMostArmWait && !opArmWaitState;

	sfm_persist u_elec (
		.core_clk(core_clk), .sys_rst(sys_rst), .msTick(msTick),
		.cond    (opRun && !elecOk),
		.limit   (restartTime), .expired(elecExp)
	);

	sfm_persist u_prewarn (
		.core_clk(core_clk), .sys_rst(sys_rst), .msTick(msTick),
		.cond    (prewarn),
		.limit   (`SFM_PREWARN_MAX_MS), .expired(prewarnExp)
	);

	sfm_persist u_quiet (
		.core_clk(core_clk), .sys_rst(sys_rst), .msTick(msTick),
		.cond    (!prewarnRise),
		.limit   (`SFM_PREWARN_MAX_MS), .expired(quietExp)
	);

	sfm_persist u_arm (
		.core_clk(core_clk), .sys_rst(sys_rst), .msTick(msTick),
		.cond    (armBad && armGate),
		.limit   (restartTime), .expired(armExp)
	);

	sfm_persist u_fldlow (
		.core_clk(core_clk), .sys_rst(sys_rst), .msTick(msTick),
		.cond    (fieldLowRaw),
		.limit   (fieldLowTimeLimit), .expired(fieldLowFlag)
	);

	sfm_persist u_field (
		.core_clk(core_clk), .sys_rst(sys_rst), .msTick(msTick),
		.cond    (fieldBad && (opRun || armGate)),
		.limit   (restartTime), .expired(fieldExp)
	);

	sfm_persist u_wait (
		.core_clk(core_clk), .sys_rst(sys_rst), .msTick(msTick),
		.cond    (opArmWaitState || opFieldWaitState),
		.limit   (powerWaitTime), .expired(waitExp)
	);

	sfm_persist u_check (
		.core_clk(core_clk), .sys_rst(sys_rst), .msTick(msTick),
		.cond    (lineContactorOn && !checkbackSeen_q),
		.limit   (checkbackTimeout), .expired(checkExp)
	);

	sfm_persist u_rev (
		.core_clk(core_clk), .sys_rst(sys_rst), .msTick(msTick),
		.cond    ((fieldReduceActive && fieldCurrentActual > fieldMinThreshold)
			|| (fieldBuildActive && fieldCurrentActual <= fieldBuildupThreshold)),
		.limit   (`SFM_REVERSAL_MS), .expired(revExp)
	);

	// ----------------------------------------
	// Prewarning repetition, checkback, outage length
	// ----------------------------------------
	logic       prewarnPrev_q;
	logic [3:0] prewarnCnt_q;
	logic       checkDrop;
	logic [7:0] tenthMs_q;
	logic [15:0] outageTenths_q;

	assign prewarnRise = prewarn && !prewarnPrev_q;
	assign checkDrop   = checkbackSeen_q && !checkback && opRun;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			prewarnPrev_q <= 1'b0;
		else
			prewarnPrev_q <= prewarn;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			prewarnCnt_q <= '0;
		else if (prewarnRise && quietExp)
			prewarnCnt_q <= 4'h1;
		else if (quietExp)
			prewarnCnt_q <= '0;
		else if (prewarnRise && prewarnCnt_q != `SFM_PREWARN_REPEAT)
			prewarnCnt_q <= prewarnCnt_q + 4'h1;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst || !lineContactorOn)
			checkbackSeen_q <= 1'b0;
		else if (checkback)
			checkbackSeen_q <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst || elecOk)
		begin
			tenthMs_q      <= '0;
			outageTenths_q <= '0;
		end
		else if (msTick)
		begin
			if (tenthMs_q == `SFM_TENTH_MS - 8'h1)
			begin
				tenthMs_q      <= '0;
				outageTenths_q <= outageTenths_q + 16'h1;
			end
			else
				tenthMs_q <= tenthMs_q + 8'h1;
		end
	end

	// ----------------------------------------
	// Fault selection
	// ----------------------------------------
	logic                raise;
	sfm_pkg::sfm_class_e selClass;
	logic [7:0]          selValue;
	logic [15:0]         selD1;
	logic [15:0]         selD2;

	always_comb
	begin
		raise    = 1'b1;
		selClass = sfm_pkg::SFM_FC_NONE;
		selValue = 8'h00;
		selD1    = 16'h0000;
		selD2    = {12'h000, opRun, opArmWaitState, opFieldWaitState, opAtMostArmWait};
		if (elecExp)
		begin
			selClass = sfm_pkg::SFM_FC_ELEC;
			selValue = `SFM_ELEC_OUTAGE;
			selD1    = outageTenths_q;
		end
		else if (prewarnExp)
		begin
			selClass = sfm_pkg::SFM_FC_ELEC;
			selValue = `SFM_ELEC_LONG;
		end
		else if (prewarnCnt_q == `SFM_PREWARN_REPEAT)
		begin
			selClass = sfm_pkg::SFM_FC_ELEC;
			selValue = `SFM_ELEC_PERIODIC;
		end
		else if (fuseBlown)
		begin
			selClass = sfm_pkg::SFM_FC_ARM;
			selValue = `SFM_ARM_FUSE;
		end
		else if (armExp)
		begin
			selClass = sfm_pkg::SFM_FC_ARM;
			selValue = (restartTime == 16'h0) ? `SFM_ARM_LOSS_NOWAIT
				: `SFM_ARM_LOSS_RESTART;
			selD1    = {{(16 - NPH){1'b0}}, phaseBad[NPH-1:0]};
		end
		else if (waitExp && opArmWaitState)
		begin
			selClass = sfm_pkg::SFM_FC_ARM;
			selValue = `SFM_ARM_WAIT_TIMEOUT;
		end
		else if (checkExp || checkDrop)
		begin
			selClass = sfm_pkg::SFM_FC_ARM;
			selValue = `SFM_ARM_CHECKBACK;
		end
		else if (fieldExp)
		begin
			selClass = sfm_pkg::SFM_FC_FIELD;
			selD1    = fieldCurrentActual;
			if (restartTime != 16'h0)
				selValue = `SFM_FLD_RESTART;
			else if (fieldVoltBad)
				selValue = `SFM_FLD_LOSS_NOWAIT;
			else
				selValue = `SFM_FLD_LOW_NOWAIT;
		end
		else if (waitExp && opFieldWaitState)
		begin
			selClass = sfm_pkg::SFM_FC_FIELD;
			selValue = fieldVoltBad ? `SFM_FLD_WAIT_VOLT : `SFM_FLD_WAIT_CURR;
			selD1    = fieldCurrentActual;
		end
		else if (revExp)
		begin
			selClass = sfm_pkg::SFM_FC_FIELD;
			selValue = fieldReduceActive ? `SFM_FLD_NO_DECAY : `SFM_FLD_NO_BUILD;
			selD1    = fieldCurrentActual;
		end
		else
			raise = 1'b0;
	end

	// ----------------------------------------
	// Fault latch
	// ----------------------------------------
	sfm_pkg::sfm_state_e state_q;
	logic                take;

	assign take        = (state_q == sfm_pkg::SFM_ST_IDLE) && raise;
	assign faultActive = (state_q == sfm_pkg::SFM_ST_HOLD);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			state_q <= sfm_pkg::SFM_ST_IDLE;
		else
		begin
			case (state_q)
				sfm_pkg::SFM_ST_IDLE:
					if (raise)
						state_q <= sfm_pkg::SFM_ST_HOLD;
				sfm_pkg::SFM_ST_HOLD:
					if (faultAck)
						state_q <= sfm_pkg::SFM_ST_IDLE;
				default:
					state_q <= sfm_pkg::SFM_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			faultClass <= sfm_pkg::SFM_FC_NONE;
			faultValue <= 8'h00;
		end
		else if (take)
		begin
			faultClass <= selClass;
			faultValue <= selValue;
		end
	end

	// ----------------------------------------
	// Detail record and value history
	// ----------------------------------------
	logic [15:0] detail_q [DETAILS];
	logic [7:0]  hist_q [HISTORY];

	generate
		for (genvar i = 0; i < DETAILS; i++)
		begin : g_detail
			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
					detail_q[i] <= '0;
				else if (take)
					detail_q[i] <= (i == 0) ? {8'h00, selValue}
						: (i == 1) ? selD1 : (i == 2) ? selD2 : 16'h0000;
			end
		end
		for (genvar j = 0; j < HISTORY; j++)
		begin : g_hist
			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
					hist_q[j] <= '0;
				else if (take)
					hist_q[j] <= (j == 0) ? selValue : hist_q[(j == 0) ? 0 : j - 1];
			end
		end
	endgenerate

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			detailData  <= '0;
			historyData <= '0;
		end
		else
		begin
			detailData  <= detail_q[detailIndex];
			historyData <= hist_q[historyIndex];
		end
	end

endmodule

//--- sfm_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps

module sfm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			meta_q  <= '0;
			syncOut <= '0;
		end
		else
		begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule

//--- test_supply_fault_monitor.sv
// Self-checking bench for the supply fault monitor
`timescale 1ns/1ps

module test_supply_fault_monitor;
	localparam logic [1:0]  CLS [12]  = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
		2'h3, 2'h3, 2'h3};
	localparam logic [7:0]  VALS [12] = '{8'h01, 8'h03, 8'h02, 8'h03, 8'h01, 8'h04, 8'h02, 8'h05,
		8'h05, 8'h05, 8'h04, 8'h03};
	localparam logic [15:0] D1 [12]   = '{16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
		16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0320, 16'h0320};

	logic        core_clk = 1'b0, sys_rst = 1'b1, elecSupplyOkPin = 1'b1, prewarnPin = 1'b0;
	logic        fuseBlownPin = 1'b0, checkbackWord = 1'b1, checkbackSourceSelect = 1'b0;
	logic        opRun = 1'b1, opArmWaitState = 1'b0, opFieldWaitState = 1'b0;
	logic        opAtMostArmWait = 1'b1, lineContactorOn = 1'b1, faultAck = 1'b0;
	logic        fieldReduceActive = 1'b0, fieldBuildActive = 1'b0, fieldLoss = 1'b0, cbFail = 1'b0;
	logic [2:0]  armLoss = 3'h0, historyIndex = 3'h0;
	logic [3:0]  detailIndex = 4'h0;
	logic [7:0]  phaseLossThresholdPct = 8'h32, fieldLowRatioLimit = 8'h32, prevVal = 8'h00;
	logic [15:0] ratedSupplyVoltage = 16'h0100, ratedFieldSupplyVoltage = 16'h0100;
	logic [15:0] restartTime = 16'h0002, powerWaitTime = 16'h0005, checkbackTimeout = 16'h0005;
	logic [15:0] fieldCurrentActual = 16'h0320, fieldCurrentSetpoint = 16'h0320;
	logic [15:0] ratedFieldCurrent = 16'h03e8, fieldLowTimeLimit = 16'h0005;
	logic [15:0] fieldMinThreshold = 16'h0064, fieldBuildupThreshold = 16'h0200;
	wire logic   degTick, fieldZeroCross, fieldRmsValid, checkbackPin, faultActive;
	wire logic [2:0]  armZeroCross, armRmsValid;
	wire logic [47:0] armRms;
	wire logic [15:0] fieldRms, detailData;
	wire logic [7:0]  faultValue, historyData;
	wire sfm_pkg::sfm_class_e faultClass;
	int          seed = 45, errors = 0, total_checks = 0;

	sfm_front_end_model sfm_front_end_model_inst (.core_clk, .armLoss, .fieldLoss,
		.contactorOn(lineContactorOn), .cbFail, .degTick, .armZeroCross, .armRmsValid, .armRms,
		.fieldZeroCross, .fieldRmsValid, .fieldRms, .checkbackPin);

	sfm_supply_fault_monitor #(.MS_CYCLES(10)) sfm_supply_fault_monitor_inst (.core_clk,
		.sys_rst, .elecSupplyOkPin, .prewarnPin, .fuseBlownPin, .checkbackPin, .checkbackWord,
		.checkbackSourceSelect, .opRun, .opArmWaitState, .opFieldWaitState, .opAtMostArmWait,
		.lineContactorOn, .degTick, .armZeroCross, .armRmsValid, .armRms, .fieldZeroCross,
		.fieldRmsValid, .fieldRms, .ratedSupplyVoltage, .ratedFieldSupplyVoltage,
		.phaseLossThresholdPct, .restartTime, .powerWaitTime, .checkbackTimeout,
		.fieldCurrentActual, .fieldCurrentSetpoint, .ratedFieldCurrent, .fieldLowRatioLimit,
		.fieldLowTimeLimit, .fieldMinThreshold, .fieldBuildupThreshold, .fieldReduceActive,
		.fieldBuildActive, .faultAck, .detailIndex, .historyIndex, .faultActive, .faultClass,
		.faultValue, .detailData, .historyData);

	initial
		forever #5 core_clk = ~core_clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	function automatic logic [15:0] expDetail(input int s, input logic [3:0] i, input logic [3:0] st);
		return (i == 4'h0) ? {8'h00, VALS[s]} : (i == 4'h1) ? D1[s] :
			(i == 4'h2) ? {12'h000, st} : 16'h0000;
	endfunction

	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// Fault cases: raise, read record, hold, clear
	// ----------------------------------------
	task automatic runCase(input int s);
		int n;
		logic [3:0] st;
		logic [3:0] ri;
		restartTime = (s == 4 || s == 9) ? 16'h0000 : 16'h0002;
		if (s == 0)
			restartTime = 16'h0064 + 16'($unsigned($random(seed)) % 64);
		case (s)
			0: elecSupplyOkPin = 1'b0;
			1: prewarnPin = 1'b1;
			2: repeat (5)
			begin
				prewarnPin = 1'b1;
				tick(20);
				prewarnPin = 1'b0;
				tick(100);
			end
			3: fuseBlownPin = 1'b1;
			4, 5: armLoss = 3'h1;
			6: {opRun, opArmWaitState, armLoss} = 5'h0f;
			7:
			begin
				lineContactorOn = 1'b0;
				cbFail = 1'b1;
				tick(2);
				lineContactorOn = 1'b1;
			end
			8: {checkbackSourceSelect, checkbackWord} = 2'h2;
			9: fieldCurrentActual = 16'h0064;
			11: {opRun, opFieldWaitState, opAtMostArmWait} = 3'h2;
			default: fieldLoss = 1'b1;
		endcase
		st = {opRun, opArmWaitState, opFieldWaitState, opAtMostArmWait};
		for (n = 0; n < 20000 && faultActive !== 1'b1; n++)
			tick(1);
		check("faultActive", 16'h0001, {15'h0000, faultActive});
		if (faultActive !== 1'b1)
			give_verdict;
		tick(3);
		check("faultClass", {14'h0000, CLS[s]}, {14'h0000, faultClass});
		check("faultValue", {8'h00, VALS[s]}, {8'h00, faultValue});
		ri = 4'h3 + 4'($unsigned($random(seed)) % 13);
		for (int i = 0; i < 4; i++)
		begin
			detailIndex = (i == 3) ? ri : 4'(i);
			historyIndex = 3'(i % 2);
			tick(2);
			check("detailData", expDetail(s, detailIndex, st), detailData);
			check("historyData", {8'h00, (i % 2) ? prevVal : VALS[s]}, {8'h00, historyData});
		end
		if (s == 3)
		begin
			elecSupplyOkPin = 1'b0;
			tick(100);
			elecSupplyOkPin = 1'b1;
			tick(2);
			check("faultValue", 16'h0003, {8'h00, faultValue});
			check("historyData", {8'h00, prevVal}, {8'h00, historyData});
		end
		{elecSupplyOkPin, prewarnPin, fuseBlownPin, armLoss, cbFail, fieldLoss} = 8'h80;
		{opRun, opArmWaitState, opFieldWaitState, opAtMostArmWait} = 4'h9;
		{checkbackWord, checkbackSourceSelect} = 2'h2;
		fieldCurrentActual = 16'h0320;
		tick((s == 2) ? 14000 : 1000);
		faultAck = 1'b1;
		tick(1);
		faultAck = 1'b0;
		tick(2);
		check("faultActive", 16'h0000, {15'h0000, faultActive});
		check("faultValue", {8'h00, VALS[s]}, {8'h00, faultValue});
		prevVal = VALS[s];
	endtask

	initial
	begin
		tick(6);
		sys_rst = 1'b0;
		tick(2);
		check("faultActive", 16'h0000, {15'h0000, faultActive});
		check("faultValue", 16'h0000, {8'h00, faultValue});
		check("detailData", 16'h0000, detailData);
		check("historyData", 16'h0000, {8'h00, historyData});
		for (int s = 0; s < 12; s++)
			runCase(s);
		give_verdict;
	end
endmodule
